// ---- inc/gpw_cfg.svh ----
/*
 * constants for the twelve-pad port: register offsets, field positions,
 * boot configuration values and timing figures.
 * assumes it is included by its bare name wherever a constant is needed.
 */
`ifndef GPW_CFG_SVH
`define GPW_CFG_SVH

`define GPW_NPADS          12
`define GPW_NPERIPH        4
// word offsets on the bus (byte addresses)
`define GPW_OFS_DIR        8'h00
`define GPW_OFS_OUT        8'h04
`define GPW_OFS_PULL_EN    8'h08
`define GPW_OFS_PULL_UP    8'h0c
`define GPW_OFS_DRIVE      8'h10
`define GPW_OFS_DEB_EN     8'h14
`define GPW_OFS_DEB_DIV    8'h18
`define GPW_OFS_IRQ_POL    8'h1c
`define GPW_OFS_WAKE_EN    8'h20
`define GPW_OFS_WAKE_LVL   8'h24
`define GPW_OFS_OSEL_LO    8'h28
`define GPW_OFS_OSEL_HI    8'h2c
`define GPW_OFS_ISEL       8'h30
`define GPW_OFS_IN_EN      8'h34
`define GPW_OFS_PIN_IN     8'h38
`define GPW_OFS_EVENT      8'h3c
`define GPW_OFS_CTRL       8'h40
`define GPW_OFS_STATUS     8'h44
// control register fields
`define GPW_CTRL_SLEEP     0
`define GPW_CTRL_CFG_MODE  1
`define GPW_CTRL_APPLIED   2
// status register fields
`define GPW_STAT_SLEEP     0
`define GPW_STAT_POR_BUSY  1
`define GPW_STAT_WOKE      2
// pads with a selectable high drive: 1,2,3,6,7
`define GPW_DRIVE_MASK     12'h0ce
// debounce division: 16 << code, codes 0..7 give 16..2048
`define GPW_DIV_MIN_LOG2   4
`define GPW_DIV_CODE_MAX   3'h7
// pad 8 indication sequence, each phase length and the core clock period in ns
`define GPW_POR_PAD        8
`define GPW_POR_PHASE_NS   10000
`define GPW_CLK_NS         100
// boot configuration mode: pads 0..4 as spi slave
// pad order: select, clock, miso, mosi, ready; miso and ready drive
`define GPW_CFG_DIR        12'h014
`define GPW_CFG_IN_EN      12'h00b
`define GPW_CFG_OSEL       2'h1
`define GPW_CFG_SPI_CNT    5

`endif

// ---- inc/gpw_pkg.sv ----
/*
 * types shared by the port modules.
 * assumes gpw_cfg.svh is compiled alongside.
 */
`default_nettype none
package gpw_pkg;
    typedef enum logic [1:0] {GPW_OSEL_GPIO, GPW_OSEL_P1, GPW_OSEL_P2,
                              GPW_OSEL_P3} gpw_osel_t;
    typedef enum {GPW_POR_DOWN1, GPW_POR_UP, GPW_POR_DOWN2,
                  GPW_POR_DONE} gpw_por_t;
endpackage : gpw_pkg
`default_nettype wire

// ---- testbench/gpio_port_with_wake_and_mux_tb.sv ----
/*
 * self-checking bench for the twelve-pad port.
 * assumes gpw_cfg.svh on the include path and gpw_pads as pad model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpw_cfg.svh"
module gpio_port_with_wake_and_mux_tb;
    logic        clk, rst_n, we, stb, cyc, ack, lf, wake;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [11:0] pin, pout, poe, pie, ppd, ppu, phd, ev, xv, xd;
    logic [47:0] po, poen;
    logic [3:0]  pi;
    int          n_errors, checked, n;

    gpw_port #(.POR_CYC(2)) uut (
        .CORE_CLK(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(4'hf), .WB_STB_I(stb),
        .WB_CYC_I(cyc), .WB_ACK_O(ack), .LF_OSC_I(lf), .PAD_IN(pin),
        .PAD_OUT(pout), .PAD_OE(poe), .PAD_IE(pie), .PAD_PULL_DN(ppd),
        .PAD_PULL_UP(ppu), .PAD_HIGH_DRIVE(phd), .PERIPH_OUT(po),
        .PERIPH_OE(poen), .PERIPH_IN(pi), .PIN_EVENT(ev), .WAKE_REQ(wake));

    gpw_pads pads (.clk(clk), .out(pout), .oe(poe), .pu(ppu), .pd(ppd),
                   .ext_val(xv), .ext_drv(xd), .pad(pin));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // odd half period keeps the oscillator out of phase with the core
    initial begin
        lf = 1'b0;
        forever #503 lf = ~lf;
    end

    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        checked++;
        if (a !== e) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, a, e);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) n_errors++;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd

    function automatic logic probe(input int s, input int i);
        case (s)
            0: return ev[i];
            1: return wake;
            2: return pi[i];
            default: return ppd[i];
        endcase
    endfunction : probe

    task automatic waitfor(input int s, input int i, input logic v,
                           input int lim);
        n = 0;
        while (probe(s, i) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk(probe(s, i), v);
    endtask : waitfor

    task automatic t_por;
        n = 0;
        for (int k = 0; k < 12; k++) begin
            @(posedge clk);
            n += ppu[8];
        end
        chk(n, 2);
        chk(ppd[8], 1'b0);
        chk(poe, 12'h0);
    endtask : t_por

    task automatic t_regs;
        for (int a = 0; a <= 8'h34; a += 4) rd(a[7:0], 32'h0);
        wr(8'h80, 32'hffff_ffff);
        rd(8'h80, 32'h0);
    endtask : t_regs

    task automatic t_cfg;
        wr(`GPW_OFS_CTRL, 32'h2);
        rd(`GPW_OFS_DIR, 32'h014);
        rd(`GPW_OFS_IN_EN, 32'h00b);
        rd(`GPW_OFS_OSEL_LO, 32'h155);
        rd(`GPW_OFS_PULL_EN, 32'h0);
        chk({poe, pie}, 24'h0);
        wr(`GPW_OFS_DIR, 32'h0);
        wr(`GPW_OFS_IN_EN, 32'h0);
        wr(`GPW_OFS_OSEL_LO, 32'h0);
    endtask : t_cfg

    task automatic t_out;
        wr(`GPW_OFS_CTRL, 32'h4);
        wr(`GPW_OFS_DIR, 32'hfff);
        wr(`GPW_OFS_OUT, 32'ha5a);
        wr(`GPW_OFS_DRIVE, 32'hfff);
        wr(`GPW_OFS_PULL_EN, 32'hfff);
        wr(`GPW_OFS_PULL_UP, 32'h0f0);
        @(posedge clk);
        chk({poe, pout}, 24'hfff_a5a);
        chk(phd, 12'h0ce);
        chk({ppu, ppd}, 24'h0f0_f0f);
        po <= 48'h2;
        poen <= 48'h2;
        wr(`GPW_OFS_OSEL_LO, 32'h1);
        @(posedge clk);
        chk({poe, pout}, 24'hfff_a5b);
        chk({ppu, ppd}, 24'h0f0_f0f);
        poen <= 48'h0;
        repeat (2) @(posedge clk);
        chk(poe, 12'hffe);
        wr(`GPW_OFS_IN_EN, 32'hfff);
        wr(`GPW_OFS_ISEL, 32'h5);
        wr(`GPW_OFS_OUT, 32'ha7a);
        waitfor(2, 0, 1'b1, 10);
        wr(`GPW_OFS_DIR, 32'h0);
        wr(`GPW_OFS_OSEL_LO, 32'h0);
        wr(`GPW_OFS_PULL_EN, 32'h0);
    endtask : t_out

    task automatic t_event;
        xd <= 12'hfff;
        xv <= 12'h002;
        wr(`GPW_OFS_IRQ_POL, 32'h1);
        repeat (5) @(posedge clk);
        wr(`GPW_OFS_EVENT, 32'hfff);
        rd(`GPW_OFS_EVENT, 32'h0);
        xv <= 12'h003;
        waitfor(0, 0, 1'b1, 4);
        chk(ev[1], 1'b0);
        xv <= 12'h001;
        waitfor(0, 1, 1'b1, 4);
        wr(`GPW_OFS_EVENT, 32'h3);
        rd(`GPW_OFS_EVENT, 32'h0);
        xv <= 12'h000;
        repeat (6) @(posedge clk);
        chk(ev, 12'h0);
    endtask : t_event

    task automatic t_wake;
        xv <= 12'h000;
        wr(`GPW_OFS_WAKE_EN, 32'h4);
        wr(`GPW_OFS_WAKE_LVL, 32'h4);
        wr(`GPW_OFS_EVENT, 32'hfff);
        wr(`GPW_OFS_CTRL, 32'h5);
        repeat (4) @(posedge clk);
        chk({wake, ev}, 13'h0);
        xv <= 12'h004;
        waitfor(1, 0, 1'b1, 4);
        waitfor(0, 2, 1'b1, 6);
        wr(`GPW_OFS_CTRL, 32'h4);
        wr(`GPW_OFS_CTRL, 32'h5);
        waitfor(1, 0, 1'b1, 4);
        rd(`GPW_OFS_STATUS, 32'h4);
        wr(`GPW_OFS_CTRL, 32'h4);
        wr(`GPW_OFS_WAKE_EN, 32'h0);
    endtask : t_wake

    task automatic t_deb;
        wr(`GPW_OFS_IRQ_POL, 32'h8);
        wr(`GPW_OFS_DEB_EN, 32'h8);
        wr(`GPW_OFS_DEB_DIV, 32'h7);
        rd(`GPW_OFS_DEB_DIV, 32'h7);
        wr(`GPW_OFS_DEB_DIV, 32'h0);
        wr(`GPW_OFS_EVENT, 32'hfff);
        xv <= 12'h00c;
        repeat (20) @(posedge clk);
        xv <= 12'h004;
        repeat (400) @(posedge clk);
        chk(ev[3], 1'b0);
        xv <= 12'h00c;
        waitfor(0, 3, 1'b1, 700);
        chk(n >= 100, 1'b1);
    endtask : t_deb

    task automatic results;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    initial begin
        #2000000;
        n_errors++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        {cyc, stb, we} = 3'b0;
        adr = 8'h0;
        wdat = 32'h0;
        {xv, xd} = 24'h0;
        {po, poen} = 96'h0;
        n_errors = 0;
        checked = 0;
        repeat (4) @(posedge clk);
        chk({poe, pie}, 24'h0);
        chk(ppu, 12'h0);
        chk(ppd, 12'h100);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_por();
        t_regs();
        t_cfg();
        t_out();
        t_event();
        t_wake();
        t_deb();
        results();
    end
endmodule : gpio_port_with_wake_and_mux_tb
`default_nettype wire

// ---- testbench/gpw_pads.sv ----
/*
 * pad-side model: external drivers plus the resolved level of each pad.
 * assumes out/oe/pulls come straight from the port, clk is the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module gpw_pads (
    input  wire logic        clk,
    input  wire logic [11:0] out,
    input  wire logic [11:0] oe,
    input  wire logic [11:0] pu,
    input  wire logic [11:0] pd,
    input  wire logic [11:0] ext_val,
    input  wire logic [11:0] ext_drv,
    output logic      [11:0] pad
);
    // a floating pad wanders each cycle so a stale level never looks valid
    logic [11:0] float_reg = 12'h5a5;

    always_ff @(posedge clk) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (oe[i])
                pad[i] = out[i];
            else if (ext_drv[i])
                pad[i] = ext_val[i];
            else if (pu[i] || pd[i])
                pad[i] = pu[i];
            else
                pad[i] = float_reg[i];
        end
    end
endmodule : gpw_pads
`default_nettype wire

// ---- verilog/gpw_debounce.sv ----
/*
 * one pad's debouncer: a new level passes after stable samples.
 * assumes din is already synchronised to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module gpw_debounce #(
    parameter int STABLE = 2
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic tick,
    input  wire logic enable,
    input  wire logic din,
    output logic      dout
);
    logic [1:0] cnt_reg;
    logic       deb_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            deb_reg <= 1'b0;
        end else if (tick) begin
            if (din == deb_reg) begin
                cnt_reg <= '0;
            end else if (cnt_reg == 2'(STABLE - 1)) begin
                deb_reg <= din; // R19
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    // bypass when off keeps the edge timing of the plain synchroniser
    assign dout = enable ? deb_reg : din;
endmodule : gpw_debounce
`default_nettype wire

// ---- verilog/gpw_port.sv ----
/*
 * twelve-pad general-purpose port with switch matrices, debounce,
 * edge events, sleep wake-up and reset / boot defaults, on a classic
 * wishbone slave.
 * assumes pads resolve from out/oe/pull signals in the bench, the
 * oscillator edge arrives asynchronously, and the interrupt manager
 * outside masks the event lines.
 */
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gpw_cfg.svh"
// Notes on behaviour
// [R1] debounce tick is oscillator divided 16..2048
// [R2] matrix picks gpio or peripheral per pad
// [R3] pulls and debounce come only from gpio
// [R4] input and output matrices are independent
// [R5] high drive only on pads 1,2,3,6,7
// [R6] per-pad direction, tri-state and pull choice
// [R7] active events fire on selected edge
// [R8] pad inputs synchronised to core clock
// [R9] masking left to outside interrupt manager
// [R10] sleep wake is level sensitive, per pin
// [R11] wake level becomes an event on waking
// [R12] wake level at sleep entry wakes immediately
// [R13] software clears wake levels before sleeping
// [R14] reset leaves every pad but pad 8 fully disabled
// [R15] pad 8 pulls down, up, down after reset
// [R16] direct boot leaves configuration all zero
// [R17] config boot makes pads 0..4 spi slave
// [R18] defaults hold until configuration applied, except high drive
// [R19] debounced level needs stable consecutive samples
module gpw_port #(
    parameter int NP       = `GPW_NPADS,
    parameter int POR_CYC  = (`GPW_POR_PHASE_NS + `GPW_CLK_NS - 1)
                             / `GPW_CLK_NS
) (
    input  wire logic            CORE_CLK,
    input  wire logic            RST_N,
    input  wire logic [7:0]      WB_ADR_I,
    input  wire logic [31:0]     WB_DAT_I,
    output logic      [31:0]     WB_DAT_O,
    input  wire logic            WB_WE_I,
    input  wire logic [3:0]      WB_SEL_I,
    input  wire logic            WB_STB_I,
    input  wire logic            WB_CYC_I,
    output logic                 WB_ACK_O,
    input  wire logic            LF_OSC_I,
    input  wire logic [NP-1:0]   PAD_IN,
    output logic      [NP-1:0]   PAD_OUT,
    output logic      [NP-1:0]   PAD_OE,
    output logic      [NP-1:0]   PAD_IE,
    output logic      [NP-1:0]   PAD_PULL_DN,
    output logic      [NP-1:0]   PAD_PULL_UP,
    output logic      [NP-1:0]   PAD_HIGH_DRIVE,
    input  wire logic [NP*4-1:0] PERIPH_OUT,
    input  wire logic [NP*4-1:0] PERIPH_OE,
    output logic      [3:0]      PERIPH_IN,
    output logic      [NP-1:0]   PIN_EVENT,
    output logic                 WAKE_REQ
);
    logic [NP-1:0] dir_reg, out_reg, pull_en_reg, pull_up_reg, drive_reg;
    logic [NP-1:0] deb_en_reg, pol_reg, wake_en_reg, wake_lvl_reg, in_en_reg;
    logic [NP-1:0] event_reg, sync1_reg, sync2_reg, prev_reg, filt;
    logic [NP-1:0] ev_set, wake_hit;
    logic [2:0]    div_reg;
    logic [23:0]   osel_reg;
    logic [15:0]   isel_reg;
    logic          sleep_reg, applied_reg, woke_reg;
    logic          osc1_reg, osc2_reg, osc3_reg, osc_edge, tick, ack_reg;
    logic [31:0]   rdata;
    logic          wr, rd;
    logic [$clog2(POR_CYC+1)-1:0] por_cnt_reg;
    gpw_pkg::gpw_por_t por_state_reg;

    assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_reg;
    assign rd = WB_CYC_I && WB_STB_I && !ack_reg;

    // two-stage synchronisers; first stages feed nothing else
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
            osc1_reg  <= 1'b0;
            osc2_reg  <= 1'b0;
            osc3_reg  <= 1'b0;
        end else begin
            sync1_reg <= PAD_IN & PAD_IE; // R8
            sync2_reg <= sync1_reg;
            prev_reg  <= filt;
            osc1_reg  <= LF_OSC_I;
            osc2_reg  <= osc1_reg;
            osc3_reg  <= osc2_reg;
        end
    end
    assign osc_edge = osc2_reg && !osc3_reg;

    gpw_tick_div u_div (
        .clk      (CORE_CLK),
        .rst_n    (RST_N),
        .osc_edge (osc_edge),
        .div_code (div_reg),
        .tick     (tick)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_deb
            gpw_debounce u_deb (
                .clk    (CORE_CLK),
                .rst_n  (RST_N),
                .tick   (tick),
                .enable (deb_en_reg[gi]), // R3
                .din    (sync2_reg[gi]),
                .dout   (filt[gi])
            );
        end
    endgenerate

    // edge events while active; wake level turns into an event too
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            ev_set[i]   = pol_reg[i] ? (filt[i] && !prev_reg[i])
                                     : (!filt[i] && prev_reg[i]); // R7
            wake_hit[i] = wake_en_reg[i]
                          && (sync2_reg[i] == wake_lvl_reg[i]); // R10
        end
    end

    // level-sensitive: a pin already at wake level wakes at once
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sleep_reg <= 1'b0;
            woke_reg  <= 1'b0;
        end else if (sleep_reg && |wake_hit) begin
            sleep_reg <= 1'b0; // R12
            woke_reg  <= 1'b1;
        end else if (wr && WB_ADR_I == `GPW_OFS_CTRL && WB_SEL_I[0]) begin
            sleep_reg <= WB_DAT_I[`GPW_CTRL_SLEEP];
            woke_reg  <= 1'b0;
        end
    end
    assign WAKE_REQ = sleep_reg && |wake_hit; // R10

    // sticky events, set beats clear; masking is outside the port
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            event_reg <= '0;
        end else begin
            event_reg <= (event_reg
                          & ~((wr && WB_ADR_I == `GPW_OFS_EVENT)
                              ? WB_DAT_I[NP-1:0] : '0))
                         | (sleep_reg ? (wake_hit & {NP{1'b1}})  // R11
                                      : ev_set);
        end
    end
    assign PIN_EVENT = event_reg; // R9

    // pad 8 indication sequence after reset
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            por_state_reg <= gpw_pkg::GPW_POR_DOWN1;
            por_cnt_reg   <= '0;
        end else if (por_state_reg != gpw_pkg::GPW_POR_DONE) begin
            if (por_cnt_reg == ($bits(por_cnt_reg))'(POR_CYC - 1)) begin
                por_cnt_reg <= '0;
                unique case (por_state_reg)
                    gpw_pkg::GPW_POR_DOWN1:
                        por_state_reg <= gpw_pkg::GPW_POR_UP;
                    gpw_pkg::GPW_POR_UP:
                        por_state_reg <= gpw_pkg::GPW_POR_DOWN2;
                    gpw_pkg::GPW_POR_DOWN2:
                        por_state_reg <= gpw_pkg::GPW_POR_DONE;
                    gpw_pkg::GPW_POR_DONE:
                        por_state_reg <= gpw_pkg::GPW_POR_DONE;
                endcase // R15
            end else begin
                por_cnt_reg <= por_cnt_reg + 1'b1;
            end
        end
    end

    // configuration registers; reset and direct boot are all zero
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            dir_reg      <= '0; // R14 R16
            out_reg      <= '0;
            pull_en_reg  <= '0;
            pull_up_reg  <= '0;
            drive_reg    <= '0;
            deb_en_reg   <= '0;
            div_reg      <= '0;
            pol_reg      <= '0;
            wake_en_reg  <= '0;
            wake_lvl_reg <= '0;
            osel_reg     <= '0;
            isel_reg     <= '0;
            in_en_reg    <= '0;
            applied_reg  <= 1'b0;
        end else if (wr) begin
            unique case (WB_ADR_I)
                `GPW_OFS_DIR:      dir_reg      <= WB_DAT_I[NP-1:0]; // R6
                `GPW_OFS_OUT:      out_reg      <= WB_DAT_I[NP-1:0];
                `GPW_OFS_PULL_EN:  pull_en_reg  <= WB_DAT_I[NP-1:0];
                `GPW_OFS_PULL_UP:  pull_up_reg  <= WB_DAT_I[NP-1:0];
                `GPW_OFS_DRIVE:    drive_reg    <= WB_DAT_I[NP-1:0]
                                                   & `GPW_DRIVE_MASK; // R5
                `GPW_OFS_DEB_EN:   deb_en_reg   <= WB_DAT_I[NP-1:0];
                `GPW_OFS_DEB_DIV:  div_reg      <= WB_DAT_I[2:0];
                `GPW_OFS_IRQ_POL:  pol_reg      <= WB_DAT_I[NP-1:0];
                `GPW_OFS_WAKE_EN:  wake_en_reg  <= WB_DAT_I[NP-1:0];
                `GPW_OFS_WAKE_LVL: wake_lvl_reg <= WB_DAT_I[NP-1:0];
                `GPW_OFS_OSEL_LO:  osel_reg[15:0]  <= WB_DAT_I[15:0];
                `GPW_OFS_OSEL_HI:  osel_reg[23:16] <= WB_DAT_I[7:0];
                `GPW_OFS_ISEL:     isel_reg     <= WB_DAT_I[15:0];
                `GPW_OFS_IN_EN:    in_en_reg    <= WB_DAT_I[NP-1:0];
                `GPW_OFS_CTRL: begin
                    // boot code in configuration mode sets the spi slave
                    if (WB_DAT_I[`GPW_CTRL_CFG_MODE]) begin
                        dir_reg     <= `GPW_CFG_DIR; // R17
                        in_en_reg   <= `GPW_CFG_IN_EN;
                        pull_en_reg <= '0;
                        for (int i = 0; i < `GPW_CFG_SPI_CNT; i++) begin
                            osel_reg[i*2 +: 2] <= `GPW_CFG_OSEL;
                        end
                    end
                    applied_reg <= WB_DAT_I[`GPW_CTRL_APPLIED];
                end
                default: ;
            endcase
        end
    end

    // output and input matrices; pulls stay under gpio control
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            PAD_OUT[i] = out_reg[i];
            PAD_OE[i]  = dir_reg[i];
            if (osel_reg[i*2 +: 2] != 2'(gpw_pkg::GPW_OSEL_GPIO)) begin
                PAD_OUT[i] = PERIPH_OUT[i*4 + int'(osel_reg[i*2 +: 2])]; // R2
                PAD_OE[i]  = PERIPH_OE[i*4 + int'(osel_reg[i*2 +: 2])];
            end
            if (!applied_reg) begin
                PAD_OE[i]  = 1'b0; // R18
                PAD_OUT[i] = 1'b0;
            end
            PAD_IE[i]         = applied_reg && in_en_reg[i];
            PAD_PULL_UP[i]    = applied_reg && pull_en_reg[i]
                                && pull_up_reg[i]; // R3
            PAD_PULL_DN[i]    = applied_reg && pull_en_reg[i]
                                && !pull_up_reg[i];
            PAD_HIGH_DRIVE[i] = drive_reg[i];
        end
        if (por_state_reg != gpw_pkg::GPW_POR_DONE) begin
            PAD_PULL_UP[`GPW_POR_PAD] = por_state_reg == gpw_pkg::GPW_POR_UP;
            PAD_PULL_DN[`GPW_POR_PAD] = por_state_reg != gpw_pkg::GPW_POR_UP;
        end
        for (int p = 0; p < 4; p++) begin
            PERIPH_IN[p] = filt[isel_reg[p*4 +: 4] % NP]; // R4
        end
    end

    always_comb begin
        rdata = '0;
        unique case (WB_ADR_I)
            `GPW_OFS_DIR:      rdata[NP-1:0] = dir_reg;
            `GPW_OFS_OUT:      rdata[NP-1:0] = out_reg;
            `GPW_OFS_PULL_EN:  rdata[NP-1:0] = pull_en_reg;
            `GPW_OFS_PULL_UP:  rdata[NP-1:0] = pull_up_reg;
            `GPW_OFS_DRIVE:    rdata[NP-1:0] = drive_reg;
            `GPW_OFS_DEB_EN:   rdata[NP-1:0] = deb_en_reg;
            `GPW_OFS_DEB_DIV:  rdata[2:0]    = div_reg;
            `GPW_OFS_IRQ_POL:  rdata[NP-1:0] = pol_reg;
            `GPW_OFS_WAKE_EN:  rdata[NP-1:0] = wake_en_reg;
            `GPW_OFS_WAKE_LVL: rdata[NP-1:0] = wake_lvl_reg;
            `GPW_OFS_OSEL_LO:  rdata[15:0]   = osel_reg[15:0];
            `GPW_OFS_OSEL_HI:  rdata[7:0]    = osel_reg[23:16];
            `GPW_OFS_ISEL:     rdata[15:0]   = isel_reg;
            `GPW_OFS_IN_EN:    rdata[NP-1:0] = in_en_reg;
            `GPW_OFS_PIN_IN:   rdata[NP-1:0] = filt;
            `GPW_OFS_EVENT:    rdata[NP-1:0] = event_reg;
            `GPW_OFS_CTRL:     rdata[`GPW_CTRL_APPLIED] = applied_reg;
            `GPW_OFS_STATUS: begin
                rdata[`GPW_STAT_SLEEP]    = sleep_reg;
                rdata[`GPW_STAT_POR_BUSY] = por_state_reg
                                            != gpw_pkg::GPW_POR_DONE;
                rdata[`GPW_STAT_WOKE]     = woke_reg;
            end
            default: rdata = '0;
        endcase
    end

    // one registered ack, a cycle after the strobe; unmapped reads return zero
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_reg  <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            ack_reg <= rd;
            if (rd) begin
                WB_DAT_O <= rdata;
            end
        end
    end
    assign WB_ACK_O = ack_reg;

    a_drive_mask: assert property (@(posedge CORE_CLK) // R5
        disable iff (!RST_N) (PAD_HIGH_DRIVE & ~`GPW_DRIVE_MASK) == '0)
        else $error("high drive on a standard pad");
    a_reset_off: assert property (@(posedge CORE_CLK) // R14
        disable iff (!RST_N) !applied_reg |-> (PAD_OE == '0 && PAD_IE == '0))
        else $error("pad enabled before configuration");
    a_event_edge: assert property (@(posedge CORE_CLK) // R7
        disable iff (!RST_N) (!sleep_reg && pol_reg[0] && $rose(filt[0]))
        |=> event_reg[0]) else $error("rising edge event missed");
    a_wake_now: assert property (@(posedge CORE_CLK) // R12
        disable iff (!RST_N) (sleep_reg && |wake_hit)
        |=> !sleep_reg && woke_reg) else $error("wake level did not wake");
    a_wake_event: assert property (@(posedge CORE_CLK) // R11
        disable iff (!RST_N) (sleep_reg && wake_hit[0]) |=> event_reg[0])
        else $error("wake gave no event");
    a_por_seq: assert property (@(posedge CORE_CLK) // R15
        disable iff (!RST_N) por_state_reg == gpw_pkg::GPW_POR_UP |->
        PAD_PULL_UP[`GPW_POR_PAD]) else $error("pad 8 pull-up phase missing");
    a_pull_excl: assert property (@(posedge CORE_CLK) // R6
        disable iff (!RST_N) (PAD_PULL_UP & PAD_PULL_DN) == '0)
        else $error("both pulls on one pad");
    a_ack_one: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held two cycles");
    c_wake: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
        sleep_reg ##1 !sleep_reg);
    c_event: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
        $rose(event_reg[0]));
    c_por_done: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
        $changed(por_state_reg) && por_state_reg == gpw_pkg::GPW_POR_DONE);
endmodule : gpw_port
`default_nettype wire

// ---- verilog/gpw_tick_div.sv ----
/*
 * divides the low-frequency oscillator into a debounce sampling tick.
 * assumes osc_edge is a one-cycle pulse already on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpw_cfg.svh"
module gpw_tick_div #(
    parameter int CW = 11
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       osc_edge,
    input  wire logic [2:0] div_code,
    output logic            tick
);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] limit;
    logic [3:0]    sh_amt;

    // division 16 << code, so one tick per 16..2048 oscillator edges;
    // the shift is widened so codes 4..7 do not wrap back to small ratios
    assign sh_amt = 4'(div_code) + 4'(`GPW_DIV_MIN_LOG2);
    assign limit  = CW'(((CW+1)'(1) << sh_amt) - (CW+1)'(1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (osc_edge) begin
                if (cnt_reg >= limit) begin
                    cnt_reg <= '0;
                    tick    <= 1'b1; // R1
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end
endmodule : gpw_tick_div
`default_nettype wire
